// >>> common/update_sync_pkg.sv
// Purpose: shared constants for the update strobe and multichip sync block
// Assumes: 32-bit Avalon-MM register words at byte offsets, core clock at 100 MHz
// Notes:   field positions, reset values and divider counts live here; the core hardcodes the sync generator divide-by-16 counter
`default_nettype none
package update_sync_pkg;
    // register byte offsets
    localparam logic [7:0]  OFF_CTRL      = 8'h00;
    localparam logic [7:0]  OFF_RATE      = 8'h04;
    localparam logic [7:0]  OFF_MCS       = 8'h08;
    localparam logic [7:0]  OFF_BUF       = 8'h0c;
    localparam logic [7:0]  OFF_ACTIVE    = 8'h10;
    localparam logic [7:0]  OFF_STATUS    = 8'h14;
    // second_control_register fields
    localparam int          CTRL_W        = 7;
    localparam int          CTRL_AUTO     = 0;
    localparam int          CTRL_RATE_LSB = 1;
    localparam int          CTRL_GEN_EN   = 3;
    localparam int          CTRL_GEN_POL  = 4;
    localparam int          CTRL_RX_EN    = 5;
    localparam int          CTRL_VAL_DIS  = 6;
    localparam logic [6:0]  CTRL_RST      = 7'h00;
    // multichip sync register fields
    localparam int          MCS_W         = 20;
    localparam int          MCS_ODLY_LSB  = 0;
    localparam int          MCS_IDLY_LSB  = 5;
    localparam int          MCS_WIN_LSB   = 10;
    localparam int          MCS_PRE_LSB   = 14;
    localparam logic [19:0] MCS_RST       = 20'h00000;
    // status fields
    localparam int          ST_ERR        = 8;
    localparam int          ST_PIN        = 9;
    localparam int          ST_AUTO       = 10;
    // reset values
    localparam logic [31:0] RATE_RST      = 32'h0000ffff;
    localparam logic [31:0] BUF_RST       = 32'h00000000;
    // counts in core clock cycles
    localparam logic [1:0]  QUARTER_LAST  = 2'h3;   // divide by 4
    localparam logic [7:0]  PULSE_BASE    = 8'h0c;  // 12 cycles at rate code 0
    localparam logic [31:0] STATIC_LIMIT  = 32'h00000003;
    localparam int          SYNC_GEN_DIV  = 16;
    localparam int          GEN_CNT_W     = $clog2(SYNC_GEN_DIV);

    // output pulse width for a rate code: 12, 24, 48 or 96 cycles
    function automatic logic [7:0] pulse_width(input logic [1:0] code);
        pulse_width = PULSE_BASE << code;
    endfunction

    // byte-lane merge of an Avalon write into an old word
    function automatic logic [31:0] merge_be(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        merge_be = r;
    endfunction
endpackage
`default_nettype wire

// >>> rtl/pin_sync2.sv
// Purpose: two-flop synchroniser for a group of asynchronous pins
// Assumes: each bit is an independent level; bits are not coherent with each other
// Notes:   the first stage feeds only the second stage
`default_nettype none
`timescale 1ns/1ps
module pin_sync2 #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             i_core_clk,
    input  wire logic             i_srst,
    // pins
    input  wire logic [WIDTH-1:0] i_async,
    // synchronised levels
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    // metastability filter, reset to a known low level
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= i_async;
            sync_q <= meta_q;
        end
    end

    assign o_sync = sync_q;
endmodule // pin_sync2
`default_nettype wire

// >>> rtl/update_sync_ctrl.sv
// Purpose: update strobe, automatic update generator, quarter-rate clock and multichip sync
// Assumes: one core clock; analog delay cells sit outside and take the delay words
// Notes:   registers reached over Avalon-MM, one wait cycle on every access
//
// Register access over Avalon-MM and the placing of the registers were chosen for this implementation.
`default_nettype none
`timescale 1ns/1ps
module update_sync_ctrl #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input  wire logic              i_core_clk,
    input  wire logic              i_srst,
    // avalon-mm slave
    input  wire logic [ADDR_W-1:0] i_avs_address,
    input  wire logic              i_avs_read,
    input  wire logic              i_avs_write,
    input  wire logic [31:0]       i_avs_writedata,
    input  wire logic [3:0]        i_avs_byteenable,
    output logic      [31:0]       o_avs_readdata,
    output logic                   o_avs_waitrequest,
    // update strobe pin and profile pins
    input  wire logic              i_update_pin,
    output logic                   o_update_pin,
    output logic                   o_update_oe,
    input  wire logic [2:0]        i_profile,
    // transfer result
    output logic [31:0]            o_active_data,
    output logic                   o_update_event,
    output logic                   o_quarter_clk,
    // sync generator
    output logic                   o_sync_clock_output,
    output logic [4:0]             o_sync_out_delay,
    // sync receiver
    input  wire logic              i_sync_clock_input,
    input  wire logic              i_sync_early,
    input  wire logic              i_sync_late,
    output logic [4:0]             o_sync_in_delay,
    output logic [3:0]             o_sync_win_delay,
    output logic                   o_sync_sampling_error,
    output logic [5:0]             o_clock_state
);
    // register state
    logic [6:0]  ctrl_q, ctrl_d;
    logic [31:0] rate_q, rate_d;
    logic [19:0] mcs_q, mcs_d;
    logic [31:0] buf_q, buf_d;
    logic [31:0] rdata_q, rdata_d;
    logic        ack_q, ack_d;
    logic        err_q, err_d;
    logic [31:0] m_ctrl, m_mcs, m_status;
    logic        wr_go;
    // update state
    logic [31:0] active_q, active_d;
    logic        pend_q, pend_d;
    logic        xfer_q, xfer_d;
    logic [1:0]  qcnt_q, qcnt_d;
    logic [2:0]  presc_q, presc_d;
    logic [31:0] ucnt_q, ucnt_d;
    logic [7:0]  pcnt_q, pcnt_d;
    logic        pin_q, pin_d;
    logic        upd_prev_q, upd_prev_d;
    logic [2:0]  prof_prev_q, prof_prev_d;
    // sync state
    logic [3:0]  gcnt_q, gcnt_d;
    logic        gen_neg_q;
    logic [5:0]  state_q, state_d;
    logic [2:0]  sin_prev_q, sin_prev_d;
    // decoded fields and events
    logic        auto_en, gen_en, gen_pol, rx_en, val_dis, b_small;
    logic [1:0]  rate_a;
    logic [5:0]  preset;
    logic [2:0]  mask;
    logic        qtick, div_tick, auto_evt, ext_rise, prof_chg, upd_req, xfer;
    logic        sync_pulse, e_rise, l_rise, miss;
    logic [6:0]  pins_s;

    // all pins come from outside the core clock domain
    pin_sync2 #(.WIDTH(7)) u_pin_sync (
        .i_core_clk (i_core_clk),
        .i_srst     (i_srst),
        .i_async    ({i_profile, i_update_pin, i_sync_clock_input, i_sync_early, i_sync_late}),
        .o_sync     (pins_s)
    );

    // field decode
    assign auto_en = ctrl_q[update_sync_pkg::CTRL_AUTO];
    assign rate_a  = ctrl_q[update_sync_pkg::CTRL_RATE_LSB +: 2];
    assign gen_en  = ctrl_q[update_sync_pkg::CTRL_GEN_EN];
    assign gen_pol = ctrl_q[update_sync_pkg::CTRL_GEN_POL];
    assign rx_en   = ctrl_q[update_sync_pkg::CTRL_RX_EN];
    assign val_dis = ctrl_q[update_sync_pkg::CTRL_VAL_DIS];
    assign preset  = mcs_q[update_sync_pkg::MCS_PRE_LSB +: 6];
    assign b_small = (rate_q <= update_sync_pkg::STATIC_LIMIT);

    // avalon handshake: first cycle waits and captures read data, second cycle completes
    assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_q;
    assign wr_go             = i_avs_write & ack_q;
    assign m_ctrl   = update_sync_pkg::merge_be({25'h0, ctrl_q}, i_avs_writedata, i_avs_byteenable);
    assign m_mcs    = update_sync_pkg::merge_be({12'h0, mcs_q}, i_avs_writedata, i_avs_byteenable);
    assign m_status = update_sync_pkg::merge_be(32'h0, i_avs_writedata, i_avs_byteenable);

    // register file next state; the buffer word is written freely and stays inert
    always_comb begin
        ctrl_d  = ctrl_q;
        rate_d  = rate_q;
        mcs_d   = mcs_q;
        buf_d   = buf_q;
        rdata_d = rdata_q;
        ack_d   = (i_avs_read | i_avs_write) & ~ack_q;
        err_d   = err_q;
        if (i_avs_read & ~ack_q) begin
            case (i_avs_address)
                update_sync_pkg::OFF_CTRL:   rdata_d = {25'h0, ctrl_q};
                update_sync_pkg::OFF_RATE:   rdata_d = rate_q;
                update_sync_pkg::OFF_MCS:    rdata_d = {12'h0, mcs_q};
                update_sync_pkg::OFF_BUF:    rdata_d = buf_q;
                update_sync_pkg::OFF_ACTIVE: rdata_d = active_q;
                update_sync_pkg::OFF_STATUS: rdata_d = {21'h0, auto_en, pin_q, err_q, 2'h0, state_q};
                default:                     rdata_d = 32'h0;     // unmapped reads as zero
            endcase
        end
        if (wr_go) begin
            case (i_avs_address)
                update_sync_pkg::OFF_CTRL:   ctrl_d = m_ctrl[6:0];
                update_sync_pkg::OFF_RATE:   rate_d = update_sync_pkg::merge_be(rate_q, i_avs_writedata,
                                                                                i_avs_byteenable);
                update_sync_pkg::OFF_MCS:    mcs_d  = m_mcs[19:0];
                update_sync_pkg::OFF_BUF:    buf_d  = update_sync_pkg::merge_be(buf_q, i_avs_writedata,
                                                                                i_avs_byteenable);
                update_sync_pkg::OFF_STATUS: begin
                    if (m_status[update_sync_pkg::ST_ERR]) begin
                        err_d = 1'b0;                            // write one to clear
                    end
                end
                default: ;                                       // unmapped writes are dropped
            endcase
        end
        // set wins over the clear in the same cycle
        if (miss) begin
            err_d = 1'b1;
        end
        if (val_dis) begin
            err_d = 1'b0;
        end
    end

    // register file flops
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            ctrl_q  <= update_sync_pkg::CTRL_RST;
            rate_q  <= update_sync_pkg::RATE_RST;
            mcs_q   <= update_sync_pkg::MCS_RST;
            buf_q   <= update_sync_pkg::BUF_RST;
            rdata_q <= 32'h0;
            ack_q   <= 1'b0;
            err_q   <= 1'b0;
        end else begin
            ctrl_q  <= ctrl_d;
            rate_q  <= rate_d;
            mcs_q   <= mcs_d;
            buf_q   <= buf_d;
            rdata_q <= rdata_d;
            ack_q   <= ack_d;
            err_q   <= err_d;
        end
    end

    // update sources and the auto generator
    assign qtick    = (qcnt_q == update_sync_pkg::QUARTER_LAST);
    assign mask     = (3'h1 << rate_a) - 3'h1;
    assign div_tick = qtick & ((presc_q & mask) == mask);
    assign auto_evt = auto_en & div_tick &
                      (({1'b0, ucnt_q} + 33'h1) >= {1'b0, rate_q});
    assign ext_rise = ~auto_en & pins_s[3] & ~upd_prev_q;
    assign prof_chg = (pins_s[6:4] != prof_prev_q);
    assign upd_req  = auto_en ? (auto_evt | prof_chg) : (ext_rise | prof_chg);
    // an asynchronous strobe lands on the next quarter tick, so a late one costs one tick
    assign xfer     = qtick & (pend_q | upd_req);

    always_comb begin
        qcnt_d      = qcnt_q + 2'h1;
        presc_d     = qtick ? (presc_q + 3'h1) : presc_q;
        ucnt_d      = ucnt_q;
        pcnt_d      = (pcnt_q != 8'h0) ? (pcnt_q - 8'h1) : 8'h0;
        pend_d      = (pend_q | upd_req) & ~qtick;
        active_d    = xfer ? buf_q : active_q;
        xfer_d      = xfer;
        upd_prev_d  = pins_s[3];
        prof_prev_d = pins_s[6:4];
        if (!auto_en) begin
            ucnt_d = 32'h0;
        end else if (div_tick) begin
            ucnt_d = auto_evt ? 32'h0 : (ucnt_q + 32'h1);
        end
        if (auto_evt) begin
            pcnt_d = update_sync_pkg::pulse_width(rate_a);
        end
        // pin drives only in auto mode; a tiny rate word pins it high
        pin_d = auto_en & (b_small | (pcnt_d != 8'h0));
    end

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            qcnt_q      <= 2'h0;
            presc_q     <= 3'h0;
            ucnt_q      <= 32'h0;
            pcnt_q      <= 8'h0;
            pend_q      <= 1'b0;
            active_q    <= 32'h0;
            xfer_q      <= 1'b0;
            pin_q       <= 1'b0;
            upd_prev_q  <= 1'b0;
            prof_prev_q <= 3'h0;
        end else begin
            qcnt_q      <= qcnt_d;
            presc_q     <= presc_d;
            ucnt_q      <= ucnt_d;
            pcnt_q      <= pcnt_d;
            pend_q      <= pend_d;
            active_q    <= active_d;
            xfer_q      <= xfer_d;
            pin_q       <= pin_d;
            upd_prev_q  <= upd_prev_d;
            prof_prev_q <= prof_prev_d;
        end
    end

    // sync receiver: edge detect on synchronised samples, validation against skewed samples
    assign sync_pulse = rx_en & pins_s[2] & ~sin_prev_q[2];
    assign e_rise     = pins_s[1] & ~sin_prev_q[1];
    assign l_rise     = pins_s[0] & ~sin_prev_q[0];
    assign miss       = rx_en & ~val_dis & ((sync_pulse ^ e_rise) | (sync_pulse ^ l_rise));

    // generator counter and clock-state counter; the latter never stops
    always_comb begin
        gcnt_d     = gen_en ? (gcnt_q + 4'h1) : 4'h0;
        state_d    = sync_pulse ? preset : (state_q + 6'h01);
        sin_prev_d = pins_s[2:0];
    end

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            gcnt_q     <= 4'h0;
            state_q    <= 6'h00;
            sin_prev_q <= 3'h0;
        end else begin
            gcnt_q     <= gcnt_d;
            state_q    <= state_d;
            sin_prev_q <= sin_prev_d;
        end
    end

    // falling-edge copy gives the half-cycle-shifted alignment choice
    always_ff @(negedge i_core_clk) begin
        gen_neg_q <= i_srst ? 1'b0 : gcnt_q[3];
    end

    // outputs
    assign o_avs_readdata        = rdata_q;
    assign o_update_pin          = pin_q;
    assign o_update_oe           = auto_en;
    assign o_active_data         = active_q;
    assign o_update_event        = xfer_q;
    assign o_quarter_clk         = qcnt_q[1];
    assign o_sync_clock_output   = gen_pol ? gen_neg_q : gcnt_q[3];
    assign o_sync_out_delay      = mcs_q[update_sync_pkg::MCS_ODLY_LSB +: 5];
    assign o_sync_in_delay       = mcs_q[update_sync_pkg::MCS_IDLY_LSB +: 5];
    assign o_sync_win_delay      = mcs_q[update_sync_pkg::MCS_WIN_LSB +: 4];
    assign o_sync_sampling_error = err_q;
    assign o_clock_state         = state_q;

    // helpers for the pulse width check; width is caught at reload so a rate change mid-pulse is harmless
    logic [7:0] hi_cnt_q;
    logic [7:0] pw_q;
    always_ff @(posedge i_core_clk) begin
        hi_cnt_q <= (i_srst | (pcnt_q == 8'h0) | auto_evt) ? 8'h0 : (hi_cnt_q + 8'h1);
        pw_q     <= i_srst ? 8'h0 : (auto_evt ? update_sync_pkg::pulse_width(rate_a) : pw_q);
    end

    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_srst);

    quarter_period_a: assert property ($rose(o_quarter_clk) |-> ##4 $rose(o_quarter_clk))
        else $error("quarter clock period is not four cycles");
    buffer_inert_a: assert property (!xfer |=> $stable(active_q))
        else $error("active data changed without an update");
    xfer_copy_a: assert property (xfer |=> o_active_data == $past(buf_q) && o_update_event)
        else $error("transfer did not copy the buffer");
    event_single_a: assert property (o_update_event |=> !o_update_event)
        else $error("update event longer than one cycle");
    strobe_update_a: assert property (ext_rise |-> ##[0:3] xfer)
        else $error("strobe edge gave no transfer");
    profile_update_a: assert property (prof_chg |-> ##[0:3] xfer)
        else $error("profile change gave no transfer");
    pulse_width_a: assert property ($fell(pcnt_q != 8'h0) |-> hi_cnt_q == pw_q)
        else $error("update pulse width wrong");
    static_high_a: assert property (auto_en && b_small |=> o_update_pin)
        else $error("strobe output not static high");
    auto_reload_a: assert property (auto_evt |=> ucnt_q == 32'h0 && pcnt_q != 8'h0 ##0 pend_q | xfer_q)
        else $error("auto reload did not restart counter and pulse");
    gen_half_a: assert property ($rose(gcnt_q[3]) |-> ##8 (!gen_en || $fell(gcnt_q[3])))
        else $error("sync generator not half period of eight");
    sync_preset_a: assert property (sync_pulse |=> o_clock_state == $past(preset))
        else $error("sync pulse did not load preset");
    state_run_a: assert property (!sync_pulse |=> o_clock_state == $past(state_q) + 6'h01)
        else $error("clock state did not step");
    pulse_single_a: assert property (sync_pulse |=> !sync_pulse)
        else $error("sync pulse longer than one cycle");
    rx_gate_a: assert property (!rx_en |-> !sync_pulse)
        else $error("sync pulse while receiver disabled");
    err_set_a: assert property (miss |=> o_sync_sampling_error)
        else $error("missed edge not flagged");
    val_off_a: assert property (val_dis |=> !o_sync_sampling_error)
        else $error("error raised while validation disabled");

    auto_evt_c:   cover property (auto_evt ##[1:200] auto_evt);
    sync_pulse_c: cover property (sync_pulse);
    strobe_c:     cover property (ext_rise ##[0:3] xfer);
    miss_c:       cover property (miss);
endmodule // update_sync_ctrl
`default_nettype wire

// >>> tb/sync_chain_model.sv
// Purpose: far-side sync chain that returns the master sync clock to its receiver
// Assumes: one core clock, equalised distribution, no analog skew
// Notes:   i_skew_bad makes the late validation copy miss its edge
`timescale 1ns/1ps
`default_nettype none
module sync_chain_model (
    // clock
    input  wire logic i_core_clk,
    // master sync clock and fault control
    input  wire logic i_src,
    input  wire logic i_skew_bad,
    // edge-aligned copies for the receiver
    output logic      o_sync,
    output logic      o_early,
    output logic      o_late
);
    // one cycle of flight; every device in the chain sees the same edge
    always_ff @(posedge i_core_clk) begin
        o_sync  <= i_src;
        o_early <= i_src;
        o_late  <= i_src & ~i_skew_bad;  // a missed edge on purpose
    end
endmodule // sync_chain_model
`default_nettype wire

// >>> tb/testbench.sv
// Purpose: register-driven test of update strobe, auto update and multichip sync
// Assumes: the slave answers within the bench's bus timeout
// Notes:   bus answers sampled at the rising edge, other outputs at the falling edge
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic        clk, srst, rd, wr, upd, bad;
    logic [7:0]  adr;
    logic [31:0] wd, q;
    logic [2:0]  prof;
    int          miscompares, comparisons, a, h, p;
    wire logic [31:0] rdat, act;
    wire logic [5:0]  cst;
    wire logic        wait_r, upin, uoe, uev, qclk, sout, sin, sea, sla, serr;
    wire logic [4:0]  odly, idly;
    wire logic [3:0]  wdly;
    update_sync_ctrl DUT (.i_core_clk(clk), .i_srst(srst), .i_avs_address(adr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hf), .o_avs_readdata(rdat),
        .o_avs_waitrequest(wait_r), .i_update_pin(upd), .o_update_pin(upin), .o_update_oe(uoe),
        .i_profile(prof), .o_active_data(act), .o_update_event(uev), .o_quarter_clk(qclk),
        .o_sync_clock_output(sout), .o_sync_out_delay(odly), .i_sync_clock_input(sin),
        .i_sync_early(sea), .i_sync_late(sla), .o_sync_in_delay(idly), .o_sync_win_delay(wdly),
        .o_sync_sampling_error(serr), .o_clock_state(cst));
    sync_chain_model far (.i_core_clk(clk), .i_src(sout), .i_skew_bad(bad), .o_sync(sin),
        .o_early(sea), .o_late(sla));
    task automatic tally_and_finish();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", s, e, g);
        end
    endtask
    // one avalon access; request held until waitrequest is seen low
    task automatic acc(input logic w_en, input logic [7:0] ad, input logic [31:0] d);
        int k;
        @(posedge clk);
        adr <= ad;
        wd  <= d;
        wr  <= w_en;
        rd  <= ~w_en;
        k = 0;
        // waitrequest and read data are taken at the completing rising edge
        do begin
            @(posedge clk);
            k++;
        end while (wait_r !== 1'b0 && k < 20);
        q = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
        if (wait_r !== 1'b0) begin
            chk("bus answer", 1, 0);
            tally_and_finish();
        end
    endtask
    // width and rise-to-rise period of the next strobe output pulse
    task automatic meas(output int hi, output int per);
        int k;
        @(negedge clk);
        for (k = 0; k < 2000 && upin !== 1'b0; k++) @(negedge clk);
        for (k = 0; k < 2000 && upin !== 1'b1; k++) @(negedge clk);
        for (hi = 0; hi < 2000 && upin === 1'b1; hi++) @(negedge clk);
        for (per = hi; per < 2000 && upin !== 1'b1; per++) @(negedge clk);
    endtask
    // high cycles and rising edges of a clock output over len cycles
    task automatic cnt(input logic sel, input int len, output int hi, output int rs);
        logic o, v;
        hi = 0;
        rs = 0;
        @(negedge clk);
        o = sel ? sout : qclk;  // reference sample so each of the len samples is compared with the one before
        repeat (len) begin
            @(negedge clk);
            v = sel ? sout : qclk;
            hi += (v === 1'b1);
            rs += (v === 1'b1 && o === 1'b0);
            o = v;
        end
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        {srst, rd, wr, upd, bad, adr, wd, prof} = {1'b1, 4'h0, 8'h00, 32'h0, 3'h0};
        {miscompares, comparisons} = 0;
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        acc(0, update_sync_pkg::OFF_RATE, 0);
        chk("rate word", update_sync_pkg::RATE_RST, q);
        acc(0, update_sync_pkg::OFF_CTRL, 0);
        chk("control", 32'h0, q);
        acc(1, update_sync_pkg::OFF_BUF, 32'h5a5a1234);
        acc(0, update_sync_pkg::OFF_ACTIVE, 0);
        chk("active unchanged", 32'h0, q);
        for (a = 0; a < 2; a++) begin
            @(posedge clk);
            if (a == 0) upd <= 1'b1;
            else prof <= 3'h5;
            for (h = 0; h < 20 && uev !== 1'b1; h++) @(negedge clk);
            chk("active after update", a ? 32'h00c3 : 32'h5a5a1234, act);
            acc(1, update_sync_pkg::OFF_BUF, 32'h00c3);
        end
        cnt(0, 32, h, p);
        chk("quarter high", 16, 32'(h));
        chk("quarter rises", 8, 32'(p));
        $display("test strobe, profile and quarter clock done");
        acc(1, update_sync_pkg::OFF_MCS, (32'h2a << update_sync_pkg::MCS_PRE_LSB) |
            (32'h9 << update_sync_pkg::MCS_WIN_LSB) | (32'h13 << update_sync_pkg::MCS_IDLY_LSB) |
            (32'hb << update_sync_pkg::MCS_ODLY_LSB));
        for (a = 0; a < 2; a++) begin
            acc(1, update_sync_pkg::OFF_CTRL, a ? 32'h38 : 32'h28);
            cnt(1, 64, h, p);
            chk("sync high", 32, 32'(h));
            chk("sync rises", 4, 32'(p));
        end
        chk("out delay", 32'hb, 32'(odly));
        chk("in delay", 32'h13, 32'(idly));
        chk("window delay", 32'h9, 32'(wdly));
        for (h = 0; h < 64 && cst !== 6'h2a; h++) @(negedge clk);
        @(negedge clk);
        chk("state after preset", 32'h2b, 32'(cst));
        p = 0;
        repeat (32) @(negedge clk) p += (cst === 6'h2a);
        chk("preset repeats", 2, 32'(p));
        @(posedge clk);
        bad <= 1'b1;
        for (h = 0; h < 64 && serr !== 1'b1; h++) @(negedge clk);
        chk("sampling error", 1, 32'(serr));
        @(posedge clk);
        bad <= 1'b0;
        repeat (20) @(negedge clk);
        acc(0, update_sync_pkg::OFF_STATUS, 0);
        chk("error held", 1, (q >> update_sync_pkg::ST_ERR) & 32'h1);
        acc(1, update_sync_pkg::OFF_STATUS, 32'h1 << update_sync_pkg::ST_ERR);
        @(negedge clk);
        chk("error cleared", 0, 32'(serr));
        @(posedge clk);
        bad <= 1'b1;
        acc(1, update_sync_pkg::OFF_CTRL, 32'h68);
        repeat (40) @(negedge clk);
        chk("error when disabled", 0, 32'(serr));
        @(posedge clk);
        bad <= 1'b0;
        $display("test sync generator and receiver done");
        acc(1, update_sync_pkg::OFF_RATE, 32'h4);
        for (a = 0; a < 4; a++) begin
            acc(1, update_sync_pkg::OFF_CTRL, 32'(1 + 2 * a));
            meas(h, p);
            chk("pulse width", 32'(12 << a), 32'(h));
            chk("auto period", 32'(16 << a), 32'(p));
            chk("pin drives", 1, 32'(uoe));
        end
        acc(1, update_sync_pkg::OFF_RATE, 32'h3);
        repeat (300) @(negedge clk);
        cnt(0, 1, h, p);
        h = 0;
        repeat (64) @(negedge clk) h += (upin === 1'b1);
        chk("static high", 64, 32'(h));
        acc(0, update_sync_pkg::OFF_STATUS, 0);
        chk("status pin and auto", 32'h3, (q >> update_sync_pkg::ST_PIN) & 32'h3);
        $display("test automatic update done");
        tally_and_finish();
    end
endmodule // testbench
`default_nettype wire
